// >>> bench/pcp_ext_pins.sv
// External circuitry on the four pins: loads, drivers and floating lines
`timescale 1ns/1ns
module pcp_ext_pins (
    input  wire logic       clk,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] pull_up,
    input  wire logic [3:0] pull_down,
    input  wire logic [3:0] ext_drv,
    input  wire logic [3:0] ext_en,
    output logic      [3:0] level
);
    logic flip = 1'b0;
    // Floating lines toggle so a stale level is never trusted
    always @(posedge clk) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) level[i] = pin_out[i];
            else if (ext_en[i]) level[i] = ext_drv[i];
            else if (pull_up[i]) level[i] = 1'b1;
            else if (pull_down[i]) level[i] = 1'b0;
            else level[i] = flip;
        end
    end
endmodule : pcp_ext_pins

// >>> bench/pcp_port_asserts.sv
// Assertions on the port's bus and pad pins
`timescale 1ns/1ns
module pcp_port_asserts
    import pcp_pkg::*;
#(
    parameter int N = PCP_NPINS
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [PCP_APB_AW-1:0] paddr,
    input wire logic [PCP_APB_DW-1:0] pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [PCP_APB_DW-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [N-1:0]          pin_in,
    input wire logic [N-1:0]          pin_out,
    input wire logic [N-1:0]          pin_oe,
    input wire logic [N-1:0]          pin_pull_up,
    input wire logic [N-1:0]          pin_pull_down
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_w;
    assign acc_w = psel && penable && pwrite && pstrb[0];

    a_data_drive: assert property (acc_w && paddr == 12'h0D8 |=>
        ((pin_out ^ $past(pwdata[N-1:0])) & pin_oe) == '0)
        else $error("driven pin differs from written data");
    a_read_stored: assert property (psel && penable && !pwrite
        && paddr == 12'h0D8 |-> ((prdata[N-1:0] ^ pin_out) & pin_oe) == '0)
        else $error("output pin read is not the stored bit");
    a_reset_pads: assert property ($rose(presetn)
        |-> pin_oe == '0 && pin_pull_up == '0 && pin_pull_down == '1)
        else $error("pads not in pull-down input after reset");
    a_pull_excl: assert property (
        (pin_pull_up & pin_pull_down) == '0)
        else $error("both pulls on");
    a_oe_nopull: assert property (
        (pin_oe & (pin_pull_up | pin_pull_down)) == '0)
        else $error("pull on while driving");
    a_dir_in: assert property (acc_w && paddr == 12'h0D4 |=>
        (pin_oe & ~$past(pwdata[N-1:0])) == '0)
        else $error("input pin driven");
    a_dir_out: assert property (acc_w && paddr == 12'h0D4 |=>
        ((pin_pull_up | pin_pull_down) & $past(pwdata[N-1:0])) == '0)
        else $error("output pin has a pull");
    a_oe_hold: assert property ($stable(pin_oe) || $past(acc_w))
        else $error("drive changed without a write");
endmodule : pcp_port_asserts

bind pcp_port pcp_port_asserts #(.N(N)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down));

// >>> bench/testbench.sv
// Self-checking bench for the four-pin port
`timescale 1ns/1ns
module testbench import pcp_pkg::*;;
    localparam logic [11:0] A_MLO = {2'h0, PCP_IDX_MODE_LO, 2'h0};
    localparam logic [11:0] A_MHI = {2'h0, PCP_IDX_MODE_HI, 2'h0};
    localparam logic [11:0] A_DIR = {2'h0, PCP_IDX_DIR, 2'h0};
    localparam logic [11:0] A_DAT = {2'h0, PCP_IDX_DATA, 2'h0};
    localparam logic [11:0] A_LVL = {2'h0, PCP_IDX_LEVEL, 2'h0};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, rerr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  pstrb = 4'hF, pin_in, pin_out, pin_oe, pin_pu, pin_pd;
    logic [3:0]  ext_drv = 4'h0, ext_en = 4'h0;
    int          miscompares = 0, checks_done = 0;
    always #5 pclk = ~pclk;
    pcp_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_up(pin_pu), .pin_pull_down(pin_pd));
    pcp_ext_pins u_ext (.clk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up(pin_pu), .pull_down(pin_pd), .ext_drv(ext_drv),
        .ext_en(ext_en), .level(pin_in));

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Master waits on pready, never on a cycle count
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [3:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {28'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A wait that runs out is a failure, not a silent skip
        if (pready !== 1'b1) miscompares++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        apb(1'b1, a, d, 4'hF);
        #1;
    endtask : wr
    task automatic t_reset(input logic again);
        logic [11:0] regs [4] = '{A_MLO, A_MHI, A_DIR, A_DAT};
        if (again) begin
            wr(A_DIR, 4'hF);
            wr(A_MLO, 4'h5);
            wr(A_DAT, 4'hF);
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            repeat (3) @(posedge pclk);
            #1;
        end
        chk("oe", pin_oe, 4'h0);
        chk("pull_down", pin_pd, 4'hF);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 4'h0, 4'hF);
            chk("reg", rdat, 32'h0);
        end
        // Input pins read the pin level, so drive out to see stored data
        wr(A_DIR, 4'hF);
        chk("data_rst", pin_out, 4'h0);
        chk("oe_cmos", pin_oe, 4'hF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_outputs;
        logic [3:0] oe_exp [4] = '{4'hF, 4'hA, 4'h5, 4'h0};
        wr(A_DIR, 4'hF);
        wr(A_DAT, 4'h5);
        for (int c = 0; c < 4; c++) begin
            wr(A_MLO, {c[1:0], c[1:0]});
            wr(A_MHI, {c[1:0], c[1:0]});
            chk("oe", pin_oe, oe_exp[c]);
            chk("drive", pin_out & pin_oe, 4'h5 & oe_exp[c]);
            chk("pulls", pin_pu | pin_pd, 4'h0);
        end
        // Pins 0 and 3 push-pull, pins 1 and 2 high impedance
        wr(A_MLO, 4'hC);
        wr(A_MHI, 4'h3);
        chk("field_map", pin_oe, 4'h9);
        wr(A_DAT, 4'hA);
        chk("pin_now", pin_out & pin_oe, 4'h8);
        apb(1'b1, A_DAT, 4'h3, 4'hE);
        apb(1'b0, A_DAT, 4'h0, 4'hF);
        chk("stored", rdat, 32'hA);
        $display("test outputs done");
    endtask : t_outputs
    task automatic t_inputs;
        wr(A_DIR, 4'h0);
        for (int c = 0; c < 4; c++) begin
            wr(A_MLO, {c[1:0], c[1:0]});
            wr(A_MHI, {c[1:0], c[1:0]});
            chk("pull_up", pin_pu, (c == 2) ? 4'hF : 4'h0);
            chk("pull_down", pin_pd, (c == 0) ? 4'hF : 4'h0);
        end
        @(posedge pclk);
        ext_en <= 4'hF;
        ext_drv <= 4'h6;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_DAT, 4'h0, 4'hF);
        chk("level", rdat, 32'h6);
        // Output pins left high impedance, the far side pulls every pin low
        wr(A_DAT, 4'hF);
        wr(A_DIR, 4'h5);
        @(posedge pclk);
        ext_drv <= 4'h0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_DAT, 4'h0, 4'hF);
        chk("mixed", rdat, 32'h5);
        ext_en <= 4'h0;
        $display("test inputs done");
    endtask : t_inputs
    task automatic t_errors;
        apb(1'b0, 12'h000, 4'h0, 4'hF);
        chk("unmapped_err", rerr, 1'b1);
        apb(1'b1, A_LVL, 4'hF, 4'hF);
        chk("readonly_err", rerr, 1'b1);
        $display("test errors done");
    endtask : t_errors
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        #50000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        t_reset(1'b0);
        t_outputs();
        t_inputs();
        t_errors();
        t_reset(1'b1);
        final_report();
    end
endmodule : testbench

// >>> common/pcp_pad_if.sv
// Pad configuration in, pad controls out, between port core and decoder
`timescale 1ns/1ns
interface pcp_pad_if #(parameter int N = 4);
    logic [N-1:0]   dir;
    logic [N-1:0]   data;
    logic [2*N-1:0] mode;
    logic [N-1:0]   out;
    logic [N-1:0]   oe;
    logic [N-1:0]   pu;
    logic [N-1:0]   pd;

    modport cfg (output dir, output data, output mode,
                 input out, input oe, input pu, input pd);
    modport pad (input dir, input data, input mode,
                 output out, output oe, output pu, output pd);
endinterface : pcp_pad_if

// >>> common/pcp_pkg.sv
// Shared constants and types for the four-pin general-purpose port
package pcp_pkg;

    localparam int          PCP_NPINS       = 4;
    localparam int          PCP_REG_W       = 4;
    localparam int          PCP_APB_AW      = 12;
    localparam int          PCP_APB_DW      = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  PCP_IDX_MODE_LO = 8'h33;
    localparam logic [7:0]  PCP_IDX_MODE_HI = 8'h34;
    localparam logic [7:0]  PCP_IDX_DIR     = 8'h35;
    localparam logic [7:0]  PCP_IDX_DATA    = 8'h36;
    localparam logic [7:0]  PCP_IDX_LEVEL   = 8'h37;

    // Reset values
    localparam logic [3:0]  PCP_RST_MODE_LO = 4'h0;
    localparam logic [3:0]  PCP_RST_MODE_HI = 4'h0;
    localparam logic [3:0]  PCP_RST_DIR     = 4'h0;
    localparam logic [3:0]  PCP_RST_DATA    = 4'h0;

    // Mode field positions inside a mode register
    localparam int          PCP_FLD_EVEN    = 0;
    localparam int          PCP_FLD_ODD     = 2;

    // Direction bit encoding
    localparam logic        PCP_DIR_IN      = 1'b0;
    localparam logic        PCP_DIR_OUT     = 1'b1;

    // Mode field codes
    localparam logic [1:0]  PCP_IN_PULLDN   = 2'h0;
    localparam logic [1:0]  PCP_IN_PULLUP   = 2'h2;
    localparam logic [1:0]  PCP_OUT_CMOS    = 2'h0;
    localparam logic [1:0]  PCP_OUT_NDRAIN  = 2'h1;
    localparam logic [1:0]  PCP_OUT_PDRAIN  = 2'h2;
    localparam logic [1:0]  PCP_OUT_HIZ     = 2'h3;

    typedef enum logic [6:0] {
        PCP_DRV_IN_PD   = 7'h01,
        PCP_DRV_IN_PU   = 7'h02,
        PCP_DRV_IN_HIZ  = 7'h04,
        PCP_DRV_OUT_PP  = 7'h08,
        PCP_DRV_OUT_ND  = 7'h10,
        PCP_DRV_OUT_PD  = 7'h20,
        PCP_DRV_OUT_HIZ = 7'h40
    } pcp_drive_e;

endpackage : pcp_pkg

// >>> src/pcp_pad_ctrl.sv
// Per-pin pad control decode from direction and mode field
`timescale 1ns/1ns
module pcp_pad_ctrl
    import pcp_pkg::*;
#(
    parameter int N = PCP_NPINS
) (
    pcp_pad_if.pad pads
);
    function automatic pcp_drive_e classify(input logic       dir,
                                            input logic [1:0] md);
        pcp_drive_e k;
        k = PCP_DRV_IN_HIZ;
        if (dir == PCP_DIR_OUT) begin
            case (md)
                PCP_OUT_CMOS:   k = PCP_DRV_OUT_PP;
                PCP_OUT_NDRAIN: k = PCP_DRV_OUT_ND;
                PCP_OUT_PDRAIN: k = PCP_DRV_OUT_PD;
                default:        k = PCP_DRV_OUT_HIZ;
            endcase
        end else if (md[0]) begin
            k = PCP_DRV_IN_HIZ;
        end else if (md == PCP_IN_PULLUP) begin
            k = PCP_DRV_IN_PU;
        end else begin
            k = PCP_DRV_IN_PD;
        end
        return k;
    endfunction : classify

    always_comb begin
        pads.out = '0;
        pads.oe  = '0;
        pads.pu  = '0;
        pads.pd  = '0;
        for (int i = 0; i < N; i++) begin
            case (classify(pads.dir[i], pads.mode[2*i +: 2]))
                PCP_DRV_IN_PD:   pads.pd[i] = 1'b1;
                PCP_DRV_IN_PU:   pads.pu[i] = 1'b1;
                PCP_DRV_IN_HIZ:  pads.oe[i] = 1'b0;
                PCP_DRV_OUT_PP: begin
                    pads.oe[i]  = 1'b1;
                    pads.out[i] = pads.data[i];
                end
                // Drain modes drive only their one active level
                PCP_DRV_OUT_ND: begin
                    pads.oe[i]  = ~pads.data[i];
                    pads.out[i] = 1'b0;
                end
                PCP_DRV_OUT_PD: begin
                    pads.oe[i]  = pads.data[i];
                    pads.out[i] = 1'b1;
                end
                PCP_DRV_OUT_HIZ: pads.oe[i] = 1'b0;
                default:         pads.oe[i] = 1'b0;
            endcase
        end
    end
endmodule : pcp_pad_ctrl

// >>> src/pcp_port.sv
// Four-pin general-purpose port with APB register access
//
// Functional notes
// - Output pins in CMOS mode drive their stored output data bit.
// - Data reads of output pins return the stored bit.
// - Data reads of input pins return the pin level.
// - Reset clears the output data register.
// - Pins change at the clock edge that completes the data write.
// - Each pin has its own direction bit.
// - Direction 0 means input, 1 means output.
// - Reset clears every direction bit, all pins input.
// - Input: 00 pull-down, 10 pull-up, low bit 1 high impedance.
// - Output: 00 CMOS, 01 N drain, 10 P drain, 11 high impedance.
// - Reset clears both mode registers.
// - Low mode register: pin 1 in bits 3:2, pin 0 in 1:0.
// - High mode register: pin 3 in bits 3:2, pin 2 in 1:0.
`timescale 1ns/1ns
module pcp_port
    import pcp_pkg::*;
#(
    parameter int N = PCP_NPINS
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PCP_APB_AW-1:0] paddr,
    input  wire logic [PCP_APB_DW-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [PCP_APB_DW-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [N-1:0]          pin_in,
    output logic      [N-1:0]          pin_out,
    output logic      [N-1:0]          pin_oe,
    output logic      [N-1:0]          pin_pull_up,
    output logic      [N-1:0]          pin_pull_down
);

    typedef enum logic [5:0] {
        PCP_SEL_NONE    = 6'h01,
        PCP_SEL_MODE_LO = 6'h02,
        PCP_SEL_MODE_HI = 6'h04,
        PCP_SEL_DIR     = 6'h08,
        PCP_SEL_DATA    = 6'h10,
        PCP_SEL_LEVEL   = 6'h20
    } pcp_sel_e;

    typedef struct packed {
        logic [PCP_REG_W-1:0]  mode_lo;
        logic [PCP_REG_W-1:0]  mode_hi;
        logic [N-1:0]          dir;
        logic [N-1:0]          data;
        logic [PCP_APB_DW-1:0] rdata;
        logic                  slverr;
        logic [N-1:0]          out;
        logic [N-1:0]          oe;
        logic [N-1:0]          pu;
        logic [N-1:0]          pd;
    } pcp_port_s;

    pcp_port_s    st;
    pcp_port_s    next_st;
    logic [N-1:0] pin_level;
    pcp_sel_e     sel;
    logic         setup_phase;
    logic         write_commit;

    pcp_pad_if #(.N(N)) pads ();

    pcp_sync #(
        .WIDTH (N)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (pin_in),
        .q     (pin_level)
    );

    pcp_pad_ctrl #(
        .N     (N)
    ) u_pad (
        .pads  (pads.pad)
    );

    function automatic logic [PCP_APB_AW-1:0] byte_addr(
        input logic [7:0] idx);
        return {{(PCP_APB_AW-10){1'b0}}, idx, 2'b00};
    endfunction : byte_addr

    function automatic pcp_sel_e decode(
        input logic [PCP_APB_AW-1:0] a);
        pcp_sel_e s;
        s = PCP_SEL_NONE;
        if (a == byte_addr(PCP_IDX_MODE_LO)) begin
            s = PCP_SEL_MODE_LO;
        end else if (a == byte_addr(PCP_IDX_MODE_HI)) begin
            s = PCP_SEL_MODE_HI;
        end else if (a == byte_addr(PCP_IDX_DIR)) begin
            s = PCP_SEL_DIR;
        end else if (a == byte_addr(PCP_IDX_DATA)) begin
            s = PCP_SEL_DATA;
        end else if (a == byte_addr(PCP_IDX_LEVEL)) begin
            s = PCP_SEL_LEVEL;
        end
        return s;
    endfunction : decode

    // Per-bit mux between stored data and pin level
    function automatic logic [N-1:0] data_view(input logic [N-1:0] d,
                                               input logic [N-1:0] dr,
                                               input logic [N-1:0] lv);
        logic [N-1:0] v;
        v = '0;
        for (int i = 0; i < N; i++) begin
            v[i] = (dr[i] == PCP_DIR_OUT) ? d[i] : lv[i];
        end
        return v;
    endfunction : data_view

    function automatic logic [PCP_APB_DW-1:0] widen(
        input logic [PCP_REG_W-1:0] v);
        return {{(PCP_APB_DW-PCP_REG_W){1'b0}}, v};
    endfunction : widen

    assign sel          = decode(paddr);
    assign setup_phase  = psel & ~penable;
    // Zero wait states, so every access phase completes
    assign write_commit = psel & penable & pwrite & pstrb[0];

    always_comb begin
        next_st = st;

        // Read data is captured in setup and held through access
        if (setup_phase) begin
            next_st.slverr = 1'b0;
            next_st.rdata  = '0;
            case (sel)
                PCP_SEL_MODE_LO: next_st.rdata = widen(st.mode_lo);
                PCP_SEL_MODE_HI: next_st.rdata = widen(st.mode_hi);
                PCP_SEL_DIR:     next_st.rdata = widen(st.dir);
                PCP_SEL_DATA: begin
                    next_st.rdata = widen(data_view(st.data, st.dir,
                                                    pin_level));
                end
                PCP_SEL_LEVEL: begin
                    next_st.rdata  = widen(pin_level);
                    next_st.slverr = pwrite;
                end
                PCP_SEL_NONE:    next_st.slverr = 1'b1;
                default:         next_st.slverr = 1'b1;
            endcase
        end

        // Writes land at the completing edge only
        if (write_commit) begin
            case (sel)
                PCP_SEL_MODE_LO: begin
                    next_st.mode_lo = pwdata[PCP_REG_W-1:0];
                end
                PCP_SEL_MODE_HI: begin
                    next_st.mode_hi = pwdata[PCP_REG_W-1:0];
                end
                PCP_SEL_DIR: begin
                    next_st.dir = pwdata[N-1:0];
                end
                PCP_SEL_DATA: begin
                    // Written even for input pins, seen once output
                    next_st.data = pwdata[N-1:0];
                end
                PCP_SEL_LEVEL:   next_st.data = st.data;
                PCP_SEL_NONE:    next_st.data = st.data;
                default:         next_st.data = st.data;
            endcase
        end

        // Pad controls follow the new register values in the same
        // edge, so pins move on the write's completing edge
        next_st.out = pads.out;
        next_st.oe  = pads.oe;
        next_st.pu  = pads.pu;
        next_st.pd  = pads.pd;
    end

    // Decoder sees next values; avoids an extra cycle of pin lag
    assign pads.dir  = next_st.dir;
    assign pads.data = next_st.data;
    assign pads.mode = {next_st.mode_hi[PCP_FLD_ODD  +: 2],
                        next_st.mode_hi[PCP_FLD_EVEN +: 2],
                        next_st.mode_lo[PCP_FLD_ODD  +: 2],
                        next_st.mode_lo[PCP_FLD_EVEN +: 2]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.mode_lo <= PCP_RST_MODE_LO;
            st.mode_hi <= PCP_RST_MODE_HI;
            st.dir     <= PCP_RST_DIR;
            st.data    <= PCP_RST_DATA;
            st.rdata   <= '0;
            st.slverr  <= 1'b0;
            st.out     <= '0;
            st.oe      <= '0;
            st.pu      <= '0;
            // Reset state is pull-down input on every pin
            st.pd      <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata        = st.rdata;
    assign pready        = 1'b1;
    assign pslverr       = st.slverr & psel & penable;
    assign pin_out       = st.out;
    assign pin_oe        = st.oe;
    assign pin_pull_up   = st.pu;
    assign pin_pull_down = st.pd;

endmodule : pcp_port

// >>> src/pcp_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module pcp_sync
    import pcp_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } pcp_sync_s;

    pcp_sync_s st;
    pcp_sync_s next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st      = st;
        next_st.meta = d;
        next_st.sync = st.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.sync;
endmodule : pcp_sync
